// ---- core/qss_cfg.svh ----
`ifndef QSS_CFG_SVH
`define QSS_CFG_SVH

// =====================================================
// register offsets
`define QSS_ADDR_RSVD_A     8'h1C
`define QSS_ADDR_RSVD_B     8'h1D
`define QSS_ADDR_SEL        8'h1E
`define QSS_ADDR_SWSYNC     8'h30
`define QSS_ADDR_OFS_SHD    8'h31
`define QSS_ADDR_CORR_SHD   8'h32
`define QSS_ADDR_OFS_ACT    8'h33
`define QSS_ADDR_CORR_ACT   8'h34

// =====================================================
// field positions
`define QSS_OFS_MSB         15
`define QSS_OFS_LSB         12
`define QSS_CORR_MSB        7
`define QSS_CORR_LSB        4
`define QSS_SWSYNC_BIT      0

// event index inside a mask, same order as the mask bits
`define QSS_EV_SW           3
`define QSS_EV_PIN          2
`define QSS_EV_STROBE       1
`define QSS_EV_AUTO         0

// =====================================================
// reset values
`define QSS_SEL_RESET       16'h1111
`define QSS_RSVD_RESET      16'h0000
`define QSS_VAL_RESET       16'h0000
`define QSS_ZERO            16'h0000

`endif

// ---- core/qss_pkg.sv ----
package qss_pkg;
   // =====================================================
   // shared types
   typedef logic [15:0] qss_word_t;
   typedef logic [3:0]  qss_mask_t;
   typedef logic [7:0]  qss_addr_t;
endpackage

// ---- core/qss_shadow_if.sv ----
`timescale 1ns/10ps
// =====================================================
// one double-buffered group: control side and storage side
interface qss_shadow_if;
   logic                 wr;
   qss_pkg::qss_word_t   wdata;
   qss_pkg::qss_mask_t   mask;
   qss_pkg::qss_mask_t   ev;
   qss_pkg::qss_word_t   shadow;
   qss_pkg::qss_word_t   active;

   modport ctrl
   (
      output wr,
      output wdata,
      output mask,
      output ev,
      input  shadow,
      input  active
   );

   modport grp
   (
      input  wr,
      input  wdata,
      input  mask,
      input  ev,
      output shadow,
      output active
   );
endinterface

// ---- core/qss_shadow.sv ----
`timescale 1ns/10ps
`include "qss_cfg.svh"

module qss_shadow
(
   // clock and reset
   input  wire logic    clk_in,
   input  wire logic    arst_n_in,
   // group link
   qss_shadow_if.grp    grp
);

   qss_pkg::qss_word_t  shadow_ff;
   qss_pkg::qss_word_t  active_ff;
   qss_pkg::qss_word_t  nxt_shadow;
   qss_pkg::qss_word_t  nxt_active;
   logic                trig;

   // =====================================================
   // update logic
   // auto-sync sits in ev bit 0, so a write alone can trigger
   always_comb
   begin
      trig       = |(grp.mask & grp.ev);
      nxt_shadow = grp.wr ? grp.wdata : shadow_ff;
      nxt_active = active_ff;
      if (trig)
      begin
         // same-cycle write wins, else the held shadow moves
         nxt_active = grp.wr ? grp.wdata : shadow_ff;
      end
   end

   // registers only
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         shadow_ff <= `QSS_VAL_RESET;
         active_ff <= `QSS_VAL_RESET;
      end
      else
      begin
         shadow_ff <= nxt_shadow;
         active_ff <= nxt_active;
      end
   end

   assign grp.shadow = shadow_ff;
   assign grp.active = active_ff;

   // =====================================================
   // checks
   property p_trig_copy;
      @(posedge clk_in) disable iff (!arst_n_in)
      (|(grp.mask & grp.ev)) && !grp.wr |=> active_ff == $past(shadow_ff);
   endproperty
   a_trig_copy: assert property (p_trig_copy) else $error("enabled event did not copy shadow");

   property p_auto_write;
      @(posedge clk_in) disable iff (!arst_n_in)
      grp.wr && grp.mask[`QSS_EV_AUTO] |=> active_ff == $past(grp.wdata) && shadow_ff == active_ff;
   endproperty
   a_auto_write: assert property (p_auto_write) else $error("auto sync write not applied");

   property p_hold_active;
      @(posedge clk_in) disable iff (!arst_n_in)
      !(|(grp.mask & grp.ev)) |=> $stable(active_ff);
   endproperty
   a_hold_active: assert property (p_hold_active) else $error("active value moved without sync");

   c_deferred_copy: cover property (@(posedge clk_in) disable iff (!arst_n_in)
      grp.wr && !grp.mask[`QSS_EV_AUTO] ##[1:20] (|(grp.mask & grp.ev)));
endmodule

// ---- core/qss_top.sv ----
`timescale 1ns/10ps
`include "qss_cfg.svh"

module qss_top
(
   // clock and reset
   input  wire logic                 SYS_CLK_IN,
   input  wire logic                 ARST_N_IN,
   // register port
   input  wire qss_pkg::qss_addr_t   REG_ADDR_IN,
   input  wire qss_pkg::qss_word_t   REG_WDATA_IN,
   input  wire logic                 REG_WR_IN,
   input  wire logic                 REG_RD_IN,
   output      qss_pkg::qss_word_t   REG_RDATA_OUT,
   // sync pins
   input  wire logic                 SYNC_IN,
   input  wire logic                 OUTPUT_STROBE_REFERENCE_IN,
   // active correction values
   output      qss_pkg::qss_word_t   OFFSET_ACTIVE_OUT,
   output      qss_pkg::qss_word_t   CORRECTION_ACTIVE_OUT
);

   localparam int NPIN = 2;

   qss_pkg::qss_word_t  sel_ff;
   qss_pkg::qss_word_t  rsvd_a_ff;
   qss_pkg::qss_word_t  rsvd_b_ff;
   qss_pkg::qss_word_t  rdata_ff;
   logic                sw_ff;
   logic                sw_prev_ff;
   logic                first_ff;
   qss_pkg::qss_word_t  nxt_sel;
   qss_pkg::qss_word_t  nxt_rsvd_a;
   qss_pkg::qss_word_t  nxt_rsvd_b;
   qss_pkg::qss_word_t  nxt_rdata;
   logic                nxt_sw;
   logic                sw_ev;
   logic [NPIN-1:0]     pin_raw;
   logic [NPIN-1:0]     pin_ev;
   logic [NPIN-1:0]     pin_lvl;
   logic                wr_sel;
   logic                wr_ofs;
   logic                wr_corr;

   qss_shadow_if        ofs_if ();
   qss_shadow_if        corr_if ();

   // =====================================================
   // write decode
   assign wr_sel  = REG_WR_IN && (REG_ADDR_IN == `QSS_ADDR_SEL);
   assign wr_ofs  = REG_WR_IN && (REG_ADDR_IN == `QSS_ADDR_OFS_SHD);
   assign wr_corr = REG_WR_IN && (REG_ADDR_IN == `QSS_ADDR_CORR_SHD);

   // =====================================================
   // pin synchronisers, one per pin
   // index 0 is the sync pin, index 1 the strobe reference
   assign pin_raw = {OUTPUT_STROBE_REFERENCE_IN, SYNC_IN};

   generate
      for (genvar gi = 0; gi < NPIN; gi++)
      begin : g_pin
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic lvl_ff;
         logic nxt_lvl;

         // a level counts only once stages two and three agree
         always_comb
         begin
            nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
         end

         always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
         begin
            if (!ARST_N_IN)
            begin
               s1_ff  <= 1'b0;
               s2_ff  <= 1'b0;
               s3_ff  <= 1'b0;
               lvl_ff <= 1'b0;
            end
            else
            begin
               s1_ff  <= pin_raw[gi];
               s2_ff  <= s1_ff;
               s3_ff  <= s2_ff;
               lvl_ff <= nxt_lvl;
            end
         end

         // rising edge of the filtered level is the event
         assign pin_ev[gi]  = nxt_lvl & ~lvl_ff;
         assign pin_lvl[gi] = lvl_ff;
      end
   endgenerate

   // =====================================================
   // register file next values
   // spare nibbles are stored as written; software keeps them at one
   always_comb
   begin
      nxt_sel    = wr_sel ? REG_WDATA_IN : sel_ff;
      nxt_rsvd_a = (REG_WR_IN && REG_ADDR_IN == `QSS_ADDR_RSVD_A) ? REG_WDATA_IN : rsvd_a_ff;
      nxt_rsvd_b = (REG_WR_IN && REG_ADDR_IN == `QSS_ADDR_RSVD_B) ? REG_WDATA_IN : rsvd_b_ff;
      nxt_sw     = (REG_WR_IN && REG_ADDR_IN == `QSS_ADDR_SWSYNC) ? REG_WDATA_IN[`QSS_SWSYNC_BIT] : sw_ff;
   end

   // =====================================================
   // read mux, data valid only in the cycle after the strobe
   always_comb
   begin
      nxt_rdata = `QSS_ZERO;
      if (REG_RD_IN)
      begin
         unique case (REG_ADDR_IN)
            `QSS_ADDR_RSVD_A:   nxt_rdata = rsvd_a_ff;
            `QSS_ADDR_RSVD_B:   nxt_rdata = rsvd_b_ff;
            `QSS_ADDR_SEL:      nxt_rdata = sel_ff;
            `QSS_ADDR_SWSYNC:   nxt_rdata = {15'h0000, sw_ff};
            `QSS_ADDR_OFS_SHD:  nxt_rdata = ofs_if.shadow;
            `QSS_ADDR_CORR_SHD: nxt_rdata = corr_if.shadow;
            `QSS_ADDR_OFS_ACT:  nxt_rdata = ofs_if.active;
            `QSS_ADDR_CORR_ACT: nxt_rdata = corr_if.active;
            default:            nxt_rdata = `QSS_ZERO;  // unmapped reads zero
         endcase
      end
   end

   // =====================================================
   // register storage
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         sel_ff     <= `QSS_SEL_RESET;
         rsvd_a_ff  <= `QSS_RSVD_RESET;
         rsvd_b_ff  <= `QSS_RSVD_RESET;
         rdata_ff   <= `QSS_ZERO;
         sw_ff      <= 1'b0;
         sw_prev_ff <= 1'b0;
         first_ff   <= 1'b1;
      end
      else
      begin
         sel_ff     <= nxt_sel;
         rsvd_a_ff  <= nxt_rsvd_a;
         rsvd_b_ff  <= nxt_rsvd_b;
         rdata_ff   <= nxt_rdata;
         sw_ff      <= nxt_sw;
         sw_prev_ff <= sw_ff;
         first_ff   <= 1'b0;
      end
   end

   // =====================================================
   // software sync event
   // only the zero-to-one step fires; a bit left at one never refires
   assign sw_ev = sw_ff & ~sw_prev_ff;

   // =====================================================
   // group hookup
   always_comb
   begin
      ofs_if.wr     = wr_ofs;
      ofs_if.wdata  = REG_WDATA_IN;
      ofs_if.mask   = sel_ff[`QSS_OFS_MSB:`QSS_OFS_LSB];
      ofs_if.ev     = {sw_ev, pin_ev[0], pin_ev[1], wr_ofs};
      corr_if.wr    = wr_corr;
      corr_if.wdata = REG_WDATA_IN;
      corr_if.mask  = sel_ff[`QSS_CORR_MSB:`QSS_CORR_LSB];
      corr_if.ev    = {sw_ev, pin_ev[0], pin_ev[1], wr_corr};
   end

   qss_shadow u_ofs
   (
      .clk_in    (SYS_CLK_IN),
      .arst_n_in (ARST_N_IN),
      .grp       (ofs_if)
   );

   qss_shadow u_corr
   (
      .clk_in    (SYS_CLK_IN),
      .arst_n_in (ARST_N_IN),
      .grp       (corr_if)
   );

   // =====================================================
   // outputs
   assign REG_RDATA_OUT         = rdata_ff;
   assign OFFSET_ACTIVE_OUT     = ofs_if.active;
   assign CORRECTION_ACTIVE_OUT = corr_if.active;

   // =====================================================
   // checks
   property p_sel_reset;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      first_ff && !$past(wr_sel) |-> sel_ff == `QSS_SEL_RESET;
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("select register reset value wrong");

   property p_rsvd_reset;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      first_ff |-> rsvd_a_ff == `QSS_RSVD_RESET && rsvd_b_ff == `QSS_RSVD_RESET;
   endproperty
   a_rsvd_reset: assert property (p_rsvd_reset) else $error("factory registers not zero at reset");

   property p_ofs_mask;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      wr_sel |=> ofs_if.mask == $past(REG_WDATA_IN[`QSS_OFS_MSB:`QSS_OFS_LSB]);
   endproperty
   a_ofs_mask: assert property (p_ofs_mask) else $error("offset mask not taken from bits 15:12");

   property p_corr_mask;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      wr_sel |=> corr_if.mask == $past(REG_WDATA_IN[`QSS_CORR_MSB:`QSS_CORR_LSB]);
   endproperty
   a_corr_mask: assert property (p_corr_mask) else $error("correction mask not taken from bits 7:4");

   property p_pin_trig;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      pin_ev[0] && corr_if.mask[`QSS_EV_PIN] && !wr_corr |=> corr_if.active == $past(corr_if.shadow);
   endproperty
   a_pin_trig: assert property (p_pin_trig) else $error("sync pin did not update correction");

   property p_sw_once;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      sw_ev |-> $rose(sw_ff) ##1 !sw_ev;
   endproperty
   a_sw_once: assert property (p_sw_once) else $error("software sync fired twice");

   property p_read_sel;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      REG_RD_IN && REG_ADDR_IN == `QSS_ADDR_SEL && !REG_WR_IN |=> REG_RDATA_OUT == $past(sel_ff);
   endproperty
   a_read_sel: assert property (p_read_sel) else $error("select register read back wrong");

   property p_no_auto_hold;
      @(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
      wr_ofs && ofs_if.mask == 4'h0 |=> $stable(OFFSET_ACTIVE_OUT);
   endproperty
   a_no_auto_hold: assert property (p_no_auto_hold) else $error("offset moved with no source enabled");

   c_pin_sync: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN) pin_ev[0] && corr_if.mask[2]);
   c_strobe: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN) pin_ev[1] && ofs_if.mask[1]);
   c_sw_sync: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN) sw_ev ##[1:10] !sw_ff);
   c_strobe_lvl: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN) pin_lvl[1]);
endmodule

// ---- dv/test_qss_top.sv ----
`timescale 1ns/10ps
`include "qss_cfg.svh"

module test_qss_top;
   // =====================================================
   // stimulus rows: select value, event kind, groups that should move
   typedef struct
   {
      logic [15:0] sel;
      int          ev;
      bit          upd_o;
      bit          upd_c;
   } qss_row_t;

   // event kinds: 0 software bit, 1 sync pin, 2 strobe reference
   // spare nibbles kept at 0001 in every select value
   qss_row_t rows [7] = '{'{16'h8181, 0, 1, 1}, '{16'h4141, 1, 1, 1}, '{16'h2121, 2, 1, 1},
                          '{16'h8141, 1, 0, 1}, '{16'h4181, 0, 0, 1}, '{16'hE1E1, 2, 1, 1},
                          '{16'h0101, 1, 0, 0}};

   logic                 sys_clk;
   logic                 arst_n;
   qss_pkg::qss_addr_t   reg_addr;
   qss_pkg::qss_word_t   reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   qss_pkg::qss_word_t   rdata;
   logic                 sync_pin;
   logic                 strobe_pin;
   qss_pkg::qss_word_t   ofs_act;
   qss_pkg::qss_word_t   corr_act;
   qss_pkg::qss_word_t   exp_o;
   qss_pkg::qss_word_t   exp_c;
   qss_pkg::qss_word_t   v_o;
   qss_pkg::qss_word_t   v_c;
   int                   n_errors;
   int                   n_compared;

   qss_top u_qss_top
   (
      .SYS_CLK_IN                 (sys_clk),
      .ARST_N_IN                  (arst_n),
      .REG_ADDR_IN                (reg_addr),
      .REG_WDATA_IN               (reg_wdata),
      .REG_WR_IN                  (reg_wr),
      .REG_RD_IN                  (reg_rd),
      .REG_RDATA_OUT              (rdata),
      .SYNC_IN                    (sync_pin),
      .OUTPUT_STROBE_REFERENCE_IN (strobe_pin),
      .OFFSET_ACTIVE_OUT          (ofs_act),
      .CORRECTION_ACTIVE_OUT      (corr_act)
   );

   // =====================================================
   // clock, 50 MHz
   always #10 sys_clk = ~sys_clk;

   // =====================================================
   // helpers
   task automatic end_of_test();
   begin
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask

   task automatic chk(input qss_pkg::qss_word_t got, input qss_pkg::qss_word_t exp);
   begin
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   // one-cycle write strobe, returns on the edge that takes it
   task automatic wr(input qss_pkg::qss_addr_t a, input qss_pkg::qss_word_t d);
   begin
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   end
   endtask

   // data is valid only in the cycle after the strobe, zero after that
   task automatic rd(input qss_pkg::qss_addr_t a, input qss_pkg::qss_word_t e);
   begin
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      chk(rdata, e);
      @(negedge sys_clk);
      chk(rdata, 16'h0000);
   end
   endtask

   // pin pulses last 4 cycles so the 3-stage filter cannot drop them
   task automatic fire(input int ev);
   begin
      if (ev == 0)
      begin
         wr(`QSS_ADDR_SWSYNC, 16'h0001);
         wr(`QSS_ADDR_SWSYNC, 16'h0000);
      end
      else
      begin
         @(posedge sys_clk);
         if (ev == 1)
            sync_pin <= 1'b1;
         else
            strobe_pin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         sync_pin   <= 1'b0;
         strobe_pin <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
   end
   endtask

   task automatic chk_act();
   begin
      @(negedge sys_clk);
      chk(ofs_act, exp_o);
      chk(corr_act, exp_c);
   end
   endtask

   // =====================================================
   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      end_of_test();
   end

   // =====================================================
   // main sequence
   initial
   begin
      sys_clk    = 1'b0;
      arst_n     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 16'h0000;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      sync_pin   = 1'b0;
      strobe_pin = 1'b0;
      n_errors   = 0;
      n_compared = 0;
      exp_o      = 16'h0000;
      exp_c      = 16'h0000;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;

      // reset values and an unmapped address
      rd(`QSS_ADDR_SEL, 16'h1111);
      rd(`QSS_ADDR_RSVD_A, 16'h0000);
      rd(`QSS_ADDR_RSVD_B, 16'h0000);
      rd(8'h00, 16'h0000);
      chk_act();
      $display("test reset done");

      // auto-sync on write is on after reset: active follows at once
      wr(`QSS_ADDR_OFS_SHD, 16'h1234);
      exp_o = 16'h1234;
      chk_act();
      wr(`QSS_ADDR_CORR_SHD, 16'hBEEF);
      exp_c = 16'hBEEF;
      chk_act();
      rd(`QSS_ADDR_OFS_ACT, 16'h1234);
      $display("test auto sync done");

      // one row per source mix: held in shadow, then moved by the event
      for (int i = 0; i < 7; i++)
      begin
         wr(`QSS_ADDR_SEL, rows[i].sel);
         rd(`QSS_ADDR_SEL, rows[i].sel);
         v_o = 16'hA000 + 16'(i);
         v_c = 16'h5000 + 16'(i);
         wr(`QSS_ADDR_OFS_SHD, v_o);
         wr(`QSS_ADDR_CORR_SHD, v_c);
         chk_act();
         fire(rows[i].ev);
         if (rows[i].upd_o)
            exp_o = v_o;
         if (rows[i].upd_c)
            exp_c = v_c;
         chk_act();
      end
      $display("test source table done");

      // software bit left high: a second one does not sync again
      wr(`QSS_ADDR_SEL, 16'h8181);
      wr(`QSS_ADDR_SWSYNC, 16'h0001);
      // shadows left over from the last row move with this first step
      exp_o = v_o;
      exp_c = v_c;
      wr(`QSS_ADDR_OFS_SHD, 16'h7777);
      wr(`QSS_ADDR_SWSYNC, 16'h0001);
      repeat (4) @(posedge sys_clk);
      chk_act();
      wr(`QSS_ADDR_SWSYNC, 16'h0000);
      wr(`QSS_ADDR_SWSYNC, 16'h0001);
      repeat (3) @(posedge sys_clk);
      exp_o = 16'h7777;
      chk_act();
      wr(`QSS_ADDR_SWSYNC, 16'h0000);
      $display("test software bit done");

      // active copies are read-only
      wr(`QSS_ADDR_CORR_ACT, 16'hFFFF);
      rd(`QSS_ADDR_CORR_ACT, exp_c);
      rd(`QSS_ADDR_OFS_SHD, 16'h7777);
      chk_act();
      $display("test read-only done");
      end_of_test();
   end
endmodule
